// *** ffa_aggregator.sv ***
// fault aggregation, enables, pin timing and apb registers
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - fault pin low while any enabled live condition is set, or in sticky mode any enabled primary flag
// - primary flags: supply low, missing, two alarms, checksum, power-on, group, secondary
// - primary enable bits only gate the pin; secondary enable bits also gate the stored secondary group flag
// - alarms and supply flags latch until the primary register is read
// - group flag is OR of wire-break flags, untouched by primary read
// - checksum flag holds from bad frame until a good frame or a mode other than 0/2
// - sticky off: pin releases when the live condition goes away
// - sticky on: pin follows enabled latched flags until read
// - each pin assertion lasts at least one microsecond
// - after reset only checksum and power-on enabled, non-sticky
// - with clear select 0 a good frame in modes 0/2 clears supply and checksum
// - checksum flag only sets in modes 0 and 2
// - monitor tied to regulated supply forces supply flags low
// - supply flags set below thresholds, each clears only when level is above its own
// - input reference short disables inputs and sets its secondary flag
// - input reference open sets its secondary flag
// - wire-break reference short forces wire-break faults, sets its flag
// - wire-break reference open suppresses faults; flag also set at reset or all off
// - thermal shutdown turns field side off, keeps registers, flags while active
// - enabled secondary flags feed the fault pin too
// - reading the wire-break register returns then clears its flags
module ffa_aggregator
(
  input  wire  logic       sys_clk,
  input  wire  logic       rst,
  input  wire  logic       psel,
  input  wire  logic       penable,
  input  wire  logic       pwrite,
  input  wire  logic [7:0] paddr,
  input  wire  logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire  logic       supply_below_low,
  input  wire  logic       supply_below_missing,
  input  wire  logic       monitor_disabled,
  input  wire  logic       overtemp_one_in,
  input  wire  logic       overtemp_two_in,
  input  wire  logic       thermal_shutdown_in,
  input  wire  logic       in_ref_short_in,
  input  wire  logic       in_ref_open_in,
  input  wire  logic       wb_ref_short_in,
  input  wire  logic       wb_ref_open_in,
  input  wire  logic [7:0] wire_break_raw,
  input  wire  logic [7:0] wire_break_detect_en,
  input  wire  logic [1:0] serial_mode,
  input  wire  logic       frame_done,
  input  wire  logic       frame_bad,
  output logic             inputs_disabled,
  output logic             field_shutdown,
  output logic             field_fault_out_n_o,
  output logic             field_fault_out_n_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [1:0]  sb_low, sb_miss, sb_mon, sb_t1, sb_t2, sb_tsd;
    logic [1:0]  sb_rs, sb_ro, sb_ws, sb_wo;
    logic [15:0] sb_wb;
    logic [7:0]  primary_fault_flags;
    logic [7:0]  secondary_fault_flags;
    logic [7:0]  primary_fault_enables;
    logic [7:0]  secondary_fault_enables;
    logic [7:0]  wire_break_flags;
    logic [1:0]  control;
    logic [6:0]  pulse_cnt;
    logic        pin_on;
    logic [31:0] rdata;
  } ffa_state_s;

  ffa_state_s cur;
  ffa_state_s next_cur;

  // synchronised pin levels, second stage only
  logic       s_low, s_miss, s_mon, s_t1, s_t2, s_tsd;
  logic       s_rs, s_ro, s_ws, s_wo;
  logic [7:0] s_wb;
  assign s_low  = cur.sb_low[1];
  assign s_miss = cur.sb_miss[1];
  assign s_mon  = cur.sb_mon[1];
  assign s_t1   = cur.sb_t1[1];
  assign s_t2   = cur.sb_t2[1];
  assign s_tsd  = cur.sb_tsd[1];
  assign s_rs   = cur.sb_rs[1];
  assign s_ro   = cur.sb_ro[1];
  assign s_ws   = cur.sb_ws[1];
  assign s_wo   = cur.sb_wo[1];
  assign s_wb   = cur.sb_wb[15:8];

  ////////////////////////////////////////////////////////////////////////////
  // next state

  logic       rd_acc, wr_acc;
  logic       rd_primary, rd_wb, good_frame, crc_mode;
  logic [7:0] wb_live, live_pri, live_sec, pri_set;
  logic       live_fault, want_pin;

  always_comb
  begin
    next_cur = cur;
    rd_acc = psel && penable && !pwrite;
    wr_acc = psel && penable && pwrite;
    rd_primary = rd_acc && (paddr == ffa_pkg::ADDR_PRIMARY_FLAGS);
    rd_wb = rd_acc && (paddr == ffa_pkg::ADDR_WIRE_BREAK);
    crc_mode = (serial_mode == ffa_pkg::MODE_ZERO) || (serial_mode == ffa_pkg::MODE_TWO);
    good_frame = frame_done && !frame_bad && crc_mode;

    // two-stage synchronisers
    next_cur.sb_low  = {cur.sb_low[0], supply_below_low};
    next_cur.sb_miss = {cur.sb_miss[0], supply_below_missing};
    next_cur.sb_mon  = {cur.sb_mon[0], monitor_disabled};
    next_cur.sb_t1   = {cur.sb_t1[0], overtemp_one_in};
    next_cur.sb_t2   = {cur.sb_t2[0], overtemp_two_in};
    next_cur.sb_tsd  = {cur.sb_tsd[0], thermal_shutdown_in};
    next_cur.sb_rs   = {cur.sb_rs[0], in_ref_short_in};
    next_cur.sb_ro   = {cur.sb_ro[0], in_ref_open_in};
    next_cur.sb_ws   = {cur.sb_ws[0], wb_ref_short_in};
    next_cur.sb_wo   = {cur.sb_wo[0], wb_ref_open_in};
    next_cur.sb_wb   = {cur.sb_wb[7:0], wire_break_raw};

    // reference pin faults override channel results
    if (s_ws)
      wb_live = wire_break_detect_en;
    else if (s_wo)
      wb_live = 8'h00;
    else
      wb_live = s_wb & wire_break_detect_en;
    if (s_tsd || s_rs)
      wb_live = 8'h00; // inputs are off, nothing to judge

    // live conditions; monitor disabled masks supply sensing
    live_pri = 8'h00;
    live_pri[ffa_pkg::P_SUPPLY_LOW]  = s_low && !s_mon;
    live_pri[ffa_pkg::P_SUPPLY_MISS] = s_miss && !s_mon;
    live_pri[ffa_pkg::P_ALARM_ONE]   = s_t1;
    live_pri[ffa_pkg::P_ALARM_TWO]   = s_t2;
    pri_set = live_pri;

    // wire-break flags: clear on read, set wins
    if (rd_wb)
      next_cur.wire_break_flags = wb_live;
    else
      next_cur.wire_break_flags = cur.wire_break_flags | wb_live;

    // primary latched flags
    for (int i = 0; i < 4; i++)
    begin
      if (rd_primary)
        next_cur.primary_fault_flags[i] = pri_set[i];
      else
        next_cur.primary_fault_flags[i] = cur.primary_fault_flags[i] | pri_set[i];
    end
    if (good_frame && !cur.control[ffa_pkg::C_SUPPLY_CSEL])
    begin
      next_cur.primary_fault_flags[ffa_pkg::P_SUPPLY_LOW] = live_pri[ffa_pkg::P_SUPPLY_LOW];
      next_cur.primary_fault_flags[ffa_pkg::P_SUPPLY_MISS] = live_pri[ffa_pkg::P_SUPPLY_MISS];
    end
    if (s_mon)
    begin
      next_cur.primary_fault_flags[ffa_pkg::P_SUPPLY_LOW] = 1'b0;
      next_cur.primary_fault_flags[ffa_pkg::P_SUPPLY_MISS] = 1'b0;
    end

    // checksum flag: set by bad frame, cleared by good frame or outside modes 0/2
    if (frame_done && crc_mode)
      next_cur.primary_fault_flags[ffa_pkg::P_CHECKSUM] = frame_bad;
    if (!crc_mode)
      next_cur.primary_fault_flags[ffa_pkg::P_CHECKSUM] = 1'b0;

    // power-on flag clears on primary read
    if (rd_primary)
      next_cur.primary_fault_flags[ffa_pkg::P_POWER_ON] = 1'b0;

    // secondary flags latch; cleared by reading them
    live_sec = 8'h00;
    live_sec[ffa_pkg::S_IN_REF_SHORT] = s_rs;
    live_sec[ffa_pkg::S_IN_REF_OPEN]  = s_ro;
    live_sec[ffa_pkg::S_WB_REF_SHORT] = s_ws;
    live_sec[ffa_pkg::S_WB_REF_OPEN]  = s_wo || (wire_break_detect_en == 8'h00);
    // shutdown recorded while it is present
    live_sec[ffa_pkg::S_THERMAL] = s_tsd;
    if (rd_acc && paddr == ffa_pkg::ADDR_SECONDARY_FLAGS)
      next_cur.secondary_fault_flags = live_sec;
    else
      next_cur.secondary_fault_flags = cur.secondary_fault_flags | live_sec;

    // group bits follow wire-break and secondary flags, not primary read clears
    next_cur.primary_fault_flags[ffa_pkg::P_WIRE_GROUP] = |next_cur.wire_break_flags;
    next_cur.primary_fault_flags[ffa_pkg::P_SECONDARY] =
      |(next_cur.secondary_fault_flags & cur.secondary_fault_enables);

    // enable and control writes; flags untouched
    if (wr_acc)
    begin
      case (paddr)
        ffa_pkg::ADDR_PRIMARY_EN:   next_cur.primary_fault_enables = pwdata[7:0];
        ffa_pkg::ADDR_SECONDARY_EN: next_cur.secondary_fault_enables = pwdata[7:0];
        ffa_pkg::ADDR_CONTROL:      next_cur.control = pwdata[1:0];
        default:                    next_cur.control = cur.control;
      endcase
    end

    // pin drive source: latched or live
    live_fault = |(live_pri & cur.primary_fault_enables)
               || (cur.primary_fault_flags[ffa_pkg::P_CHECKSUM]
                   && cur.primary_fault_enables[ffa_pkg::P_CHECKSUM])
               || (cur.primary_fault_flags[ffa_pkg::P_POWER_ON]
                   && cur.primary_fault_enables[ffa_pkg::P_POWER_ON])
               || (|wb_live && cur.primary_fault_enables[ffa_pkg::P_WIRE_GROUP])
               || (|(live_sec & cur.secondary_fault_enables)
                   && cur.primary_fault_enables[ffa_pkg::P_SECONDARY]);
    if (cur.control[ffa_pkg::C_STICKY])
      want_pin = |(cur.primary_fault_flags & cur.primary_fault_enables);
    else
      want_pin = live_fault;

    // minimum pulse stretch
    if (want_pin && !cur.pin_on)
    begin
      next_cur.pin_on = 1'b1;
      next_cur.pulse_cnt = ffa_pkg::PULSE_LOAD;
    end
    else if (cur.pulse_cnt != 7'h00)
      next_cur.pulse_cnt = cur.pulse_cnt - 7'h01;
    else
      next_cur.pin_on = want_pin;

    // read mux, registered
    next_cur.rdata = 32'h00000000;
    case (paddr)
      ffa_pkg::ADDR_PRIMARY_FLAGS:   next_cur.rdata[7:0] = cur.primary_fault_flags;
      ffa_pkg::ADDR_SECONDARY_FLAGS: next_cur.rdata[7:0] = cur.secondary_fault_flags;
      ffa_pkg::ADDR_PRIMARY_EN:      next_cur.rdata[7:0] = cur.primary_fault_enables;
      ffa_pkg::ADDR_SECONDARY_EN:    next_cur.rdata[7:0] = cur.secondary_fault_enables;
      ffa_pkg::ADDR_WIRE_BREAK:      next_cur.rdata[7:0] = cur.wire_break_flags;
      ffa_pkg::ADDR_CONTROL:         next_cur.rdata[1:0] = cur.control;
      ffa_pkg::ADDR_STATUS:          next_cur.rdata[2:0] = {cur.pin_on, s_tsd, s_rs};
      default:                       next_cur.rdata = 32'h00000000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cur <= '0;
      cur.primary_fault_flags <= ffa_pkg::PRIMARY_RESET;
      cur.secondary_fault_flags <= ffa_pkg::SECONDARY_RESET;
      cur.primary_fault_enables <= ffa_pkg::PRIMARY_EN_RESET;
      cur.secondary_fault_enables <= ffa_pkg::SECONDARY_EN_RESET;
      cur.control <= ffa_pkg::CONTROL_RESET;
    end
    else
      cur <= next_cur;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  // no wait state: read data registered in the setup cycle
  assign pready  = psel && penable;
  assign prdata  = cur.rdata;
  assign pslverr = 1'b0;
  assign inputs_disabled = s_rs || s_tsd;
  assign field_shutdown = s_tsd;
  assign field_fault_out_n_o = 1'b0;
  assign field_fault_out_n_oe = cur.pin_on;

endmodule // ffa_aggregator

`default_nettype wire

// *** ffa_aggregator_props.sv ***
// port checker for the fault aggregator
`timescale 1ns/1ps
`default_nettype none
module ffa_aggregator_props
(
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        in_ref_short_in,
  input wire logic        thermal_shutdown_in,
  input wire logic        inputs_disabled,
  input wire logic        field_shutdown,
  input wire logic        field_fault_out_n_o,
  input wire logic        field_fault_out_n_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // saturates so a long fault cannot wrap
  logic [7:0] hi_len;
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
      hi_len <= 8'h0;
    else if (field_fault_out_n_oe)
      hi_len <= (hi_len == 8'hFF) ? hi_len : hi_len + 8'h1;
    else
      hi_len <= 8'h0;
  a_no_error: assert property (pslverr == 1'b0) else $error("slave error raised");
  a_zero_wait: assert property (psel && penable |-> pready) else $error("no ready");
  a_read_upper: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_pin_low: assert property (field_fault_out_n_o == 1'b0) else $error("pin not low");
  a_pulse_min: assert property ($fell(field_fault_out_n_oe) |-> hi_len >= 8'h64)
    else $error("fault pulse short");
  a_power_on: assert property ($fell(rst) |-> ##[1:6] field_fault_out_n_oe)
    else $error("no power-on fault");
  a_short_off: assert property ($rose(in_ref_short_in) |-> ##[1:4] inputs_disabled)
    else $error("inputs not disabled");
  a_thermal_off: assert property ($rose(thermal_shutdown_in) |-> ##[1:4] field_shutdown)
    else $error("no shutdown");
endmodule // ffa_aggregator_props
bind ffa_aggregator ffa_aggregator_props props
(
  .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pready(pready), .prdata(prdata), .pslverr(pslverr), .in_ref_short_in(in_ref_short_in),
  .thermal_shutdown_in(thermal_shutdown_in), .inputs_disabled(inputs_disabled),
  .field_shutdown(field_shutdown), .field_fault_out_n_o(field_fault_out_n_o),
  .field_fault_out_n_oe(field_fault_out_n_oe)
);
`default_nettype wire

// *** ffa_host_model.sv ***
// host side of the fault wire: pull-up and low pulse timer
`timescale 1ns/1ps
`default_nettype none
module ffa_host_model
(
  input  wire logic        sys_clk,
  input  wire logic        pin_oe,
  input  wire logic        pin_o,
  output logic             line_n,
  output logic [15:0]      low_len
);
  logic [15:0] run = 16'h0;
  initial low_len = 16'h0;
  // released wire goes to the pull-up level
  assign line_n = pin_oe ? pin_o : 1'b1;
  always @(posedge sys_clk)
  begin
    if (!line_n)
      run <= run + 16'h1;
    else
      run <= 16'h0;
    if (line_n && run != 16'h0)
      low_len <= run;
  end
endmodule // ffa_host_model
`default_nettype wire

// *** ffa_pkg.sv ***
// package of constants for the field fault aggregator
package ffa_pkg;
  // apb register byte offsets
  localparam logic [7:0] ADDR_PRIMARY_FLAGS   = 8'h00;
  localparam logic [7:0] ADDR_SECONDARY_FLAGS = 8'h04;
  localparam logic [7:0] ADDR_PRIMARY_EN      = 8'h08;
  localparam logic [7:0] ADDR_SECONDARY_EN    = 8'h0C;
  localparam logic [7:0] ADDR_WIRE_BREAK      = 8'h10;
  localparam logic [7:0] ADDR_CONTROL         = 8'h14;
  localparam logic [7:0] ADDR_STATUS          = 8'h18;

  // primary flag positions
  localparam int P_SUPPLY_LOW  = 0;
  localparam int P_SUPPLY_MISS = 1;
  localparam int P_ALARM_ONE   = 2;
  localparam int P_ALARM_TWO   = 3;
  localparam int P_CHECKSUM    = 4;
  localparam int P_POWER_ON    = 5;
  localparam int P_WIRE_GROUP  = 6;
  localparam int P_SECONDARY   = 7;

  // secondary flag positions
  localparam int S_IN_REF_SHORT = 0;
  localparam int S_IN_REF_OPEN  = 1;
  localparam int S_WB_REF_SHORT = 2;
  localparam int S_WB_REF_OPEN  = 3;
  localparam int S_THERMAL      = 4;

  // control register fields
  localparam int C_STICKY      = 0;
  localparam int C_SUPPLY_CSEL = 1;

  // reset values
  localparam logic [7:0] PRIMARY_EN_RESET   = 8'h30;
  localparam logic [7:0] SECONDARY_EN_RESET = 8'h00;
  localparam logic [1:0] CONTROL_RESET      = 2'h0;
  localparam logic [7:0] PRIMARY_RESET      = 8'h20;
  localparam logic [7:0] SECONDARY_RESET    = 8'h08;

  // minimum fault pin pulse
  localparam int  CLK_MHZ       = 100;
  localparam int  MIN_PULSE_NS  = 1000;
  localparam int  PULSE_CYCLES  = (MIN_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam logic [6:0] PULSE_LOAD = 7'(PULSE_CYCLES - 1);

  localparam logic [1:0] MODE_ZERO = 2'h0;
  localparam logic [1:0] MODE_TWO  = 2'h2;
endpackage

// *** tb.sv ***
// self-checking bench for the fault aggregator
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [7:0] A_PF = ffa_pkg::ADDR_PRIMARY_FLAGS;
  localparam logic [7:0] A_SF = ffa_pkg::ADDR_SECONDARY_FLAGS;
  localparam logic [7:0] A_PE = ffa_pkg::ADDR_PRIMARY_EN;
  localparam logic [7:0] A_SE = ffa_pkg::ADDR_SECONDARY_EN;
  localparam logic [7:0] A_WB = ffa_pkg::ADDR_WIRE_BREAK;
  localparam logic [7:0] A_CT = ffa_pkg::ADDR_CONTROL;
  logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, wb_raw, wb_en;
  logic [31:0] pwdata, prdata, rd;
  logic        s_low, s_miss, mon_dis, ot1, ot2, tsd, irs, iro, wrs, wro;
  logic        ins_dis, shut, pin_o, pin_oe, line_n, fdone, fbad;
  logic [1:0]  mode;
  logic [15:0] low_len;
  int          bad_count, checks;
  ffa_aggregator uut
  (
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .supply_below_low(s_low), .supply_below_missing(s_miss), .monitor_disabled(mon_dis),
    .overtemp_one_in(ot1), .overtemp_two_in(ot2), .thermal_shutdown_in(tsd),
    .in_ref_short_in(irs), .in_ref_open_in(iro), .wb_ref_short_in(wrs), .wb_ref_open_in(wro),
    .wire_break_raw(wb_raw), .wire_break_detect_en(wb_en), .serial_mode(mode),
    .frame_done(fdone), .frame_bad(fbad), .inputs_disabled(ins_dis), .field_shutdown(shut),
    .field_fault_out_n_o(pin_o), .field_fault_out_n_oe(pin_oe)
  );
  ffa_host_model host
  (
    .sys_clk(sys_clk), .pin_oe(pin_oe), .pin_o(pin_o), .line_n(line_n), .low_len(low_len)
  );
  always #5 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////////////
  task check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // idle edge first, so a back-to-back call never drives psel twice at once
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    @(posedge sys_clk);
    while (pready !== 1'b1 && n < 16)
    begin
      @(posedge sys_clk);
      n++;
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd, e);
  endtask
  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task frame(input logic bad);
    @(posedge sys_clk);
    fdone <= 1'b1;
    fbad <= bad;
    @(posedge sys_clk);
    fdone <= 1'b0;
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #100000;
    bad_count++;
    end_sim;
  end
  initial
  begin
    {sys_clk, psel, penable, pwrite, paddr, pwdata, s_low, s_miss, mon_dis} = '0;
    {ot1, ot2, tsd, irs, iro, wrs, wro, wb_raw, mode, fdone, fbad} = '0;
    wb_en = 8'hFF;
    rst = 1'b1;
    cyc(16);
    rst <= 1'b0;
    rdchk(A_PE, 32'h30);
    rdchk(A_SE, 32'h0);
    rdchk(A_CT, 32'h0);
    rdchk(8'h1C, 32'h0);
    rdchk(A_PF, 32'h20);
    rdchk(A_PF, 32'h0);
    rdchk(A_SF, 32'h08);
    rdchk(A_SF, 32'h0);
    cyc(120);
    $display("reset values done");
    apb(1'b1, A_PE, 32'h1);
    s_low <= 1'b1;
    cyc(8);
    check(line_n, 1'b0);
    apb(1'b1, A_PE, 32'h0);
    cyc(110);
    check(line_n, 1'b1);
    rdchk(A_PF, 32'h1);
    s_low <= 1'b0;
    cyc(4);
    rdchk(A_PF, 32'h1);
    rdchk(A_PF, 32'h0);
    apb(1'b1, A_PE, 32'h1);
    s_low <= 1'b1;
    cyc(3);
    s_low <= 1'b0;
    cyc(6);
    check(line_n, 1'b0);
    cyc(120);
    check(line_n, 1'b1);
    check(low_len >= 16'h64, 1'b1);
    rdchk(A_PF, 32'h1);
    $display("supply and pin done");
    apb(1'b1, A_CT, 32'h1);
    apb(1'b1, A_PE, 32'h4);
    {ot1, ot2} <= 2'h3;
    cyc(3);
    {ot1, ot2} <= 2'h0;
    cyc(200);
    check(line_n, 1'b0);
    rdchk(A_PF, 32'h0C);
    cyc(3);
    check(line_n, 1'b1);
    apb(1'b1, A_CT, 32'h0);
    $display("sticky done");
    for (int m = 0; m < 4; m++)
    begin
      mode <= m[1:0];
      frame(1'b1);
      cyc(3);
      rdchk(A_PF, m[0] ? 32'h0 : 32'h10);
      rdchk(A_PF, m[0] ? 32'h0 : 32'h10);
      s_low <= 1'b1;
      cyc(3);
      s_low <= 1'b0;
      cyc(4);
      frame(1'b0);
      cyc(3);
      rdchk(A_PF, m[0] ? 32'h1 : 32'h0);
    end
    $display("checksum done");
    wb_raw <= 8'h05;
    cyc(4);
    wb_raw <= 8'h00;
    cyc(4);
    rdchk(A_PF, 32'h40);
    rdchk(A_PF, 32'h40);
    rdchk(A_WB, 32'h05);
    rdchk(A_WB, 32'h0);
    rdchk(A_PF, 32'h0);
    {mon_dis, s_low, s_miss} <= 3'h7;
    cyc(6);
    rdchk(A_PF, 32'h0);
    {mon_dis, s_low, s_miss} <= 3'h0;
    cyc(1);
    {s_low, s_miss} <= 2'h3;
    cyc(4);
    {s_low, s_miss} <= 2'h0;
    cyc(4);
    rdchk(A_PF, 32'h3);
    $display("wire break and monitor done");
    apb(1'b1, A_SE, 32'h02);
    apb(1'b1, A_PE, 32'h80);
    {irs, iro, tsd} <= 3'h7;
    cyc(5);
    {irs, iro, tsd} <= 3'h0;
    cyc(4);
    check(line_n, 1'b0);
    rdchk(ffa_pkg::ADDR_STATUS, 32'h4);
    rdchk(A_PF, 32'h80);
    rdchk(A_SF, 32'h13);
    wrs <= 1'b1;
    cyc(5);
    wrs <= 1'b0;
    cyc(4);
    rdchk(A_WB, 32'hFF);
    rdchk(A_SF, 32'h04);
    wro <= 1'b1;
    wb_raw <= 8'hFF;
    cyc(5);
    {wro, wb_raw} <= 9'h0;
    cyc(4);
    rdchk(A_WB, 32'h0);
    rdchk(A_SF, 32'h08);
    rdchk(A_SF, 32'h0);
    wb_en <= 8'h00;
    cyc(4);
    rdchk(A_SF, 32'h08);
    $display("secondary done");
    end_sim;
  end
endmodule // tb
`default_nettype wire
